// [rtl/dma_err_consts.svh]
// Register offsets, field positions, reset values and limits of the block.
`ifndef DMA_ERR_CONSTS_SVH
`define DMA_ERR_CONSTS_SVH
`define OFS_MISS_STAT_LO   6'h00
`define OFS_MISS_STAT_HI   6'h04
`define OFS_MISS_CLR_LO    6'h08
`define OFS_MISS_CLR_HI    6'h0C
`define OFS_QMISS_STAT     6'h10
`define OFS_QMISS_CLR      6'h14
`define OFS_CTRL_ERR       6'h18
`define OFS_CTRL_ERR_CLR   6'h1C
`define OFS_QUEUE_WM       6'h20
`define OFS_IRQ_STAT       6'h24
`define OFS_IRQ_CLR        6'h28
`define OFS_IRQ_EN         6'h2C
`define CTRL_TCC_POS       16
`define CTRL_TCC_IDX       6
`define QUEUE_WM_RESET     32'h2108_4210
`define TCC_MAX_OUT        7'h3F
`endif

// [rtl/dma_err_pkg.sv]
// Shared types of the DMA error status block.
package dma_err_pkg;
  typedef logic [31:0] word_t;
  typedef enum logic {ACC_IDLE, ACC_ANSWER} acc_state_t;
endpackage

// [rtl/sticky_if.sv]
// Set, clear and flag vector of one bank of sticky error flags.
interface sticky_if #(parameter int W = 32);
  logic [W-1:0] set;
  logic [W-1:0] clr;
  logic [W-1:0] flags;
  modport src  (output set, output clr, input flags);
  modport bank (input set, input clr, output flags);
endinterface

// [rtl/sticky_flags.sv]
// Bank of sticky flags, set by hardware and cleared by writing ones.
module sticky_flags #(
  parameter int W = 32
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic ARST_N,
  // Flag bank
  sticky_if.bank   sb
);
  logic [W-1:0] flags;
  logic [W-1:0] next_flags;
  logic [W-1:0] clr_only;

  // A set in the same cycle as a clear wins, so no error is lost.
  always_comb
  begin
    next_flags = (flags & ~sb.clr) | sb.set;
    clr_only   = sb.clr & ~sb.set;
  end

  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      flags <= '0;
    else
      flags <= next_flags;
  end

  assign sb.flags = flags;

  a_set_wins: assert property (@(posedge CLK) disable iff (!ARST_N)
    (sb.set != '0) |=> ((flags & $past(sb.set)) == $past(sb.set)))
    else $error("set flag bit did not stick");
  a_flag_hold: assert property (@(posedge CLK) disable iff (!ARST_N)
    1'b1 |=> ((flags & $past(flags) & ~$past(sb.clr))
              == ($past(flags) & ~$past(sb.clr))))
    else $error("flag dropped without a clear");
  a_clear_ones: assert property (@(posedge CLK) disable iff (!ARST_N)
    (clr_only != '0) |=> ((flags & $past(clr_only)) == '0))
    else $error("write of one failed to clear flag");
endmodule

// [rtl/dma_error_status.sv]
// Missed-event, queue threshold and completion code error status block.
// Contract
// - Second event on a channel before service sets its missed bit, per trigger.
// - Event meeting a null entry, or null request serviced, sets missed bit.
// - Upper missed status word holds channels 32 to 63, one bit each.
// - Missed status bits stay set until software clears them via clear word.
// - Writing one to a clear bit clears status; zero leaves it unchanged.
// - Lower clear word covers channels 0-31, upper covers 32-63, same order.
// - Two quick events without service set that quick channel's missed bit.
// - Quick event meeting null entry, or null request, sets quick missed bit.
// - Quick missed status uses bits 7-0; bits 31-8 read zero.
// - Quick missed bit stays until software writes one to its clear bit.
// - Error interrupt fires when a bit sets while all error bits were clear.
// - Queue threshold flag sets when queued count reaches the watermark.
// - Completion code flag sets when outstanding coded requests exceed 63.
// - Controller error flags stay set until cleared through their clear word.
// - Controller error word: completion flag bit 16, queues 0-5 bits 0-5.
`include "dma_err_consts.svh"
module dma_error_status #(
  parameter int NQ  = 6,
  parameter int QLW = 5
) (
  // Clock and reset
  input  wire logic              CLK,
  input  wire logic              ARST_N,
  // Avalon-MM slave
  input  wire logic [5:0]        AVS_ADDRESS,
  input  wire logic              AVS_READ,
  input  wire logic              AVS_WRITE,
  input  wire logic [31:0]       AVS_WRITEDATA,
  input  wire logic [3:0]        AVS_BYTEENABLE,
  output      logic [31:0]       AVS_READDATA,
  output      logic              AVS_WAITREQUEST,
  // DMA channel events, one-cycle pulses per channel
  input  wire logic [63:0]       EVT_MANUAL,
  input  wire logic [63:0]       EVT_CHAIN,
  input  wire logic [63:0]       EVT_HW,
  input  wire logic [63:0]       EVT_SERVICED,
  input  wire logic [63:0]       EVT_NULL,
  // Quick DMA channel events, one-cycle pulses per channel
  input  wire logic [7:0]        QEVT,
  input  wire logic [7:0]        QEVT_SERVICED,
  input  wire logic [7:0]        QEVT_NULL,
  // Event queue levels and completion code count
  input  wire logic [NQ*QLW-1:0] QUEUE_LEVEL,
  input  wire logic [6:0]        TCC_OUTSTANDING,
  // Interrupts
  output      logic              ERR_INT,
  output      logic              IRQ
);
  dma_err_pkg::word_t      rdata;
  dma_err_pkg::word_t      next_rdata;
  dma_err_pkg::word_t      rd_mux;
  dma_err_pkg::word_t      wmask;
  dma_err_pkg::word_t      wdata_m;
  dma_err_pkg::word_t      queue_wm;
  dma_err_pkg::word_t      next_queue_wm;
  dma_err_pkg::acc_state_t state;
  dma_err_pkg::acc_state_t next_state;
  logic                    wait_q;
  logic                    next_wait;
  logic                    wr_acc;
  logic                    irq_en;
  logic                    next_irq_en;
  logic [63:0]             pend_m;
  logic [63:0]             pend_c;
  logic [63:0]             pend_h;
  logic [63:0]             next_pend_m;
  logic [63:0]             next_pend_c;
  logic [63:0]             next_pend_h;
  logic [63:0]             miss64;
  logic [7:0]              qpend;
  logic [7:0]              next_qpend;
  logic [7:0]              qmiss;
  logic [NQ-1:0]           thr_hit;
  logic                    tcc_over;
  logic                    any_err;
  logic                    any_prev;
  logic                    next_err_int;
  logic                    next_irq;

  sticky_if #(.W(32)) miss_lo ();
  sticky_if #(.W(32)) miss_hi ();
  sticky_if #(.W(8))  qmiss_b ();
  sticky_if #(.W(7))  ctrl_b ();
  sticky_if #(.W(1))  irq_b ();

  sticky_flags #(.W(32)) u_miss_lo (.CLK(CLK), .ARST_N(ARST_N), .sb(miss_lo));
  sticky_flags #(.W(32)) u_miss_hi (.CLK(CLK), .ARST_N(ARST_N), .sb(miss_hi));
  sticky_flags #(.W(8))  u_qmiss   (.CLK(CLK), .ARST_N(ARST_N), .sb(qmiss_b));
  sticky_flags #(.W(7))  u_ctrl    (.CLK(CLK), .ARST_N(ARST_N), .sb(ctrl_b));
  sticky_flags #(.W(1))  u_irq     (.CLK(CLK), .ARST_N(ARST_N), .sb(irq_b));

  // Each trigger kind keeps its own pending bit; service clears all three.
  always_comb
  begin
    next_pend_m = (pend_m & ~EVT_SERVICED) | EVT_MANUAL;
    next_pend_c = (pend_c & ~EVT_SERVICED) | EVT_CHAIN;
    next_pend_h = (pend_h & ~EVT_SERVICED) | EVT_HW;
    next_qpend  = (qpend & ~QEVT_SERVICED) | QEVT;
    miss64 = (((EVT_MANUAL & pend_m) | (EVT_CHAIN & pend_c)
             | (EVT_HW & pend_h)) & ~EVT_SERVICED)
             | EVT_NULL;
    qmiss = (QEVT & qpend & ~QEVT_SERVICED)
            | QEVT_NULL;
  end

  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      pend_m <= '0;
      pend_c <= '0;
      pend_h <= '0;
      qpend  <= '0;
    end
    else
    begin
      pend_m <= next_pend_m;
      pend_c <= next_pend_c;
      pend_h <= next_pend_h;
      qpend  <= next_qpend;
    end
  end

  // Threshold compare uses >= so a queue sitting at its mark is flagged.
  always_comb
  begin
    for (int i = 0; i < NQ; i++)
    begin
      thr_hit[i] = QUEUE_LEVEL[i*QLW +: QLW]
                   >= queue_wm[i*QLW +: QLW];
    end
    tcc_over = TCC_OUTSTANDING > `TCC_MAX_OUT;
  end

  // Bus side: one wait cycle, then the answer; writes act on the answer edge.
  always_comb
  begin
    wmask = {{8{AVS_BYTEENABLE[3]}}, {8{AVS_BYTEENABLE[2]}},
             {8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}};
    wdata_m = AVS_WRITEDATA & wmask;
    wr_acc  = (state == dma_err_pkg::ACC_ANSWER) && AVS_WRITE;
    case (AVS_ADDRESS)
      `OFS_MISS_STAT_LO: rd_mux = miss_lo.flags;
      `OFS_MISS_STAT_HI: rd_mux = miss_hi.flags;
      `OFS_QMISS_STAT:   rd_mux = {24'h00_0000, qmiss_b.flags};
      `OFS_CTRL_ERR:     rd_mux = {15'h0000, ctrl_b.flags[`CTRL_TCC_IDX],
                                   10'h000, ctrl_b.flags[NQ-1:0]};
      `OFS_QUEUE_WM:     rd_mux = queue_wm;
      `OFS_IRQ_STAT:     rd_mux = {31'h0000_0000, irq_b.flags};
      `OFS_IRQ_EN:       rd_mux = {31'h0000_0000, irq_en};
      default:           rd_mux = 32'h0000_0000;
    endcase
    next_state = state;
    next_wait  = 1'b1;
    next_rdata = rdata;
    case (state)
      dma_err_pkg::ACC_IDLE:
      begin
        if (AVS_READ || AVS_WRITE)
        begin
          next_state = dma_err_pkg::ACC_ANSWER;
          next_wait  = 1'b0;
          next_rdata = AVS_READ ? rd_mux : 32'h0000_0000;
        end
      end
      dma_err_pkg::ACC_ANSWER:
        next_state = dma_err_pkg::ACC_IDLE;
      default:
        next_state = dma_err_pkg::ACC_IDLE;
    endcase
    next_queue_wm = queue_wm;
    next_irq_en   = irq_en;
    if (wr_acc && AVS_ADDRESS == `OFS_QUEUE_WM)
      next_queue_wm = (queue_wm & ~wmask) | wdata_m;
    if (wr_acc && AVS_ADDRESS == `OFS_IRQ_EN && AVS_BYTEENABLE[0])
      next_irq_en = AVS_WRITEDATA[0];
  end

  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      state           <= dma_err_pkg::ACC_IDLE;
      wait_q          <= 1'b1;
      rdata           <= 32'h0000_0000;
      queue_wm        <= `QUEUE_WM_RESET;
      irq_en          <= 1'b0;
    end
    else
    begin
      state           <= next_state;
      wait_q          <= next_wait;
      rdata           <= next_rdata;
      queue_wm        <= next_queue_wm;
      irq_en          <= next_irq_en;
    end
  end

  assign AVS_READDATA    = rdata;
  assign AVS_WAITREQUEST = wait_q;

  // Sticky banks: hardware sets, one-bits of a clear write clear.
  always_comb
  begin
    miss_lo.set = miss64[31:0];
    miss_hi.set = miss64[63:32];
    qmiss_b.set = qmiss;
    ctrl_b.set  = {tcc_over, thr_hit};
    miss_lo.clr = '0;
    miss_hi.clr = '0;
    qmiss_b.clr = '0;
    ctrl_b.clr  = '0;
    irq_b.clr   = '0;
    if (wr_acc)
    begin
      case (AVS_ADDRESS)
        `OFS_MISS_CLR_LO:  miss_lo.clr = wdata_m;
        `OFS_MISS_CLR_HI:  miss_hi.clr = wdata_m;
        `OFS_QMISS_CLR:    qmiss_b.clr = wdata_m[7:0];
        `OFS_CTRL_ERR_CLR: ctrl_b.clr  = {wdata_m[`CTRL_TCC_POS],
                                          wdata_m[NQ-1:0]};
        `OFS_IRQ_CLR:      irq_b.clr   = wdata_m[0:0];
        default:           miss_lo.clr = '0;
      endcase
    end
  end

  // ERR_INT and the irq flag only fire on the step from no error to some error, so
  // software must empty all four error banks before it can see another one.
  always_comb
  begin
    any_err = (|miss_lo.flags) | (|miss_hi.flags) | (|qmiss_b.flags)
              | (|ctrl_b.flags);
    next_err_int = any_err && !any_prev;
    irq_b.set    = next_err_int;
    next_irq     = irq_b.flags[0] && irq_en;
  end

  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      any_prev <= 1'b0;
      ERR_INT  <= 1'b0;
      IRQ      <= 1'b0;
    end
    else
    begin
      any_prev <= any_err;
      ERR_INT  <= next_err_int;
      IRQ      <= next_irq;
    end
  end

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!ARST_N);

  a_missed_detect: assert property (
    (miss64 != '0) |=> (({miss_hi.flags, miss_lo.flags} & $past(miss64))
                       == $past(miss64)))
    else $error("missed event not posted");
  a_null_entry: assert property (
    (EVT_NULL != '0) |=> (({miss_hi.flags, miss_lo.flags} & $past(EVT_NULL))
                         == $past(EVT_NULL)))
    else $error("null entry not posted");
  a_quick_missed: assert property (
    (qmiss != '0) |=> ((qmiss_b.flags & $past(qmiss)) == $past(qmiss)))
    else $error("quick missed event not posted");
  a_err_first: assert property (
    $rose(any_err) |=> ERR_INT ##1 !ERR_INT)
    else $error("error interrupt missing on first error");
  a_err_cause: assert property (
    ERR_INT |-> $past(any_err) && !$past(any_prev))
    else $error("error interrupt without first error");
  a_queue_thresh: assert property (
    thr_hit[0] |=> ctrl_b.flags[0])
    else $error("queue threshold flag not set");
  a_tcc_over: assert property (
    (TCC_OUTSTANDING > `TCC_MAX_OUT) |=> ctrl_b.flags[`CTRL_TCC_IDX])
    else $error("completion code flag not set");
  a_clear_reads: assert property (
    (state == dma_err_pkg::ACC_ANSWER && AVS_READ
     && AVS_ADDRESS == `OFS_MISS_CLR_LO) |-> AVS_READDATA == 32'h0000_0000)
    else $error("clear register read not zero");
  a_quick_reserved: assert property (
    (state == dma_err_pkg::ACC_ANSWER && AVS_READ
     && AVS_ADDRESS == `OFS_QMISS_STAT) |-> AVS_READDATA[31:8] == 24'h0)
    else $error("quick status reserved bits set");
  a_bus_answer: assert property (
    (state == dma_err_pkg::ACC_IDLE && (AVS_READ || AVS_WRITE))
    |=> !AVS_WAITREQUEST ##1 AVS_WAITREQUEST)
    else $error("bus answer not after one wait cycle");

  c_missed: cover property (miss64 != '0);
  c_err_int: cover property (ERR_INT);
  c_irq: cover property (IRQ);
  c_set_and_clear: cover property ((miss_lo.set & miss_lo.clr) != '0);
endmodule

// [tb/dma_error_status_test.sv]
// Self-checking testbench of the DMA error status block.
`include "dma_err_consts.svh"
module dma_error_status_test;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    int                 k;
    int                 ch;
    logic [5:0]         sa;
    logic [5:0]         ca;
    dma_err_pkg::word_t v;
  } row_t;
  localparam row_t ROWS [11] = '{
    '{0, 0, `OFS_MISS_STAT_LO, `OFS_MISS_CLR_LO, 32'h0000_0001},
    '{1, 31, `OFS_MISS_STAT_LO, `OFS_MISS_CLR_LO, 32'h8000_0000},
    '{2, 32, `OFS_MISS_STAT_HI, `OFS_MISS_CLR_HI, 32'h0000_0001},
    '{2, 63, `OFS_MISS_STAT_HI, `OFS_MISS_CLR_HI, 32'h8000_0000},
    '{3, 40, `OFS_MISS_STAT_HI, `OFS_MISS_CLR_HI, 32'h0000_0100},
    '{4, 0, `OFS_QMISS_STAT, `OFS_QMISS_CLR, 32'h0000_0001},
    '{4, 7, `OFS_QMISS_STAT, `OFS_QMISS_CLR, 32'h0000_0080},
    '{5, 3, `OFS_QMISS_STAT, `OFS_QMISS_CLR, 32'h0000_0008},
    '{6, 0, `OFS_CTRL_ERR, `OFS_CTRL_ERR_CLR, 32'h0000_0001},
    '{6, 5, `OFS_CTRL_ERR, `OFS_CTRL_ERR_CLR, 32'h0000_0020},
    '{7, 0, `OFS_CTRL_ERR, `OFS_CTRL_ERR_CLR, 32'h0001_0000}};
  logic               clk = 1'b0;
  logic               arst_n = 1'b0;
  logic [5:0]         address = 6'h00;
  logic               rd = 1'b0;
  logic               wr = 1'b0;
  dma_err_pkg::word_t wdata = 32'h0000_0000;
  dma_err_pkg::word_t rdata;
  logic               waitreq;
  logic [63:0]        ev_man = 64'h0;
  logic [63:0]        ev_chn = 64'h0;
  logic [63:0]        ev_hw = 64'h0;
  logic [63:0]        ev_srv = 64'h0;
  logic [63:0]        ev_nul = 64'h0;
  logic [7:0]         qev = 8'h00;
  logic [7:0]         qsrv = 8'h00;
  logic [7:0]         qnul = 8'h00;
  logic [29:0]        qlevel = 30'h0;
  logic [6:0]         tcc_out = 7'h00;
  logic               err_int;
  logic               irq;
  int                 err_total = 0;
  int                 compares = 0;
  int                 cycles = 0;
  int                 pulses = 0;
  int                 p;
  dma_err_pkg::word_t q;
  dma_error_status dma_error_status_i (
    .CLK(clk), .ARST_N(arst_n), .AVS_ADDRESS(address), .AVS_READ(rd),
    .AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(4'hF),
    .AVS_READDATA(rdata), .AVS_WAITREQUEST(waitreq), .EVT_MANUAL(ev_man),
    .EVT_CHAIN(ev_chn), .EVT_HW(ev_hw), .EVT_SERVICED(ev_srv),
    .EVT_NULL(ev_nul), .QEVT(qev), .QEVT_SERVICED(qsrv), .QEVT_NULL(qnul),
    .QUEUE_LEVEL(qlevel), .TCC_OUTSTANDING(tcc_out), .ERR_INT(err_int),
    .IRQ(irq));
  initial
  begin
    forever #4 clk = ~clk;
  end
  task stop_test;
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // The ceiling is far above the few hundred cycles the run needs.
  always @(posedge clk)
  begin
    cycles++;
    if (err_int === 1'b1)
      pulses++;
    if (cycles == 5000)
    begin
      err_total++;
      stop_test;
    end
  end
  task chk(input dma_err_pkg::word_t s, input dma_err_pkg::word_t e);
    compares++;
    if (s !== e)
    begin
      err_total++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task bus(input logic w, input logic [5:0] a, input dma_err_pkg::word_t d);
    @(posedge clk);
    address <= a;
    wdata <= d;
    rd <= ~w;
    wr <= w;
    // Only the bench ceiling may end this wait; the slave sets the pace.
    do
      @(posedge clk);
    while (waitreq !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task rdchk(input logic [5:0] a, input dma_err_pkg::word_t e);
    bus(1'b0, a, 32'h0000_0000);
    chk(q, e);
  endtask
  task fire(input int k, input int ch);
    @(posedge clk);
    case (k)
      0: ev_man[ch] <= 1'b1;
      1: ev_chn[ch] <= 1'b1;
      2: ev_hw[ch] <= 1'b1;
      3: ev_nul[ch] <= 1'b1;
      4: qev[ch] <= 1'b1;
      5: qnul[ch] <= 1'b1;
      6: qlevel[5*ch +: 5] <= 5'h10;
      7: tcc_out <= 7'h40;
      default: ev_srv[ch] <= 1'b1;
    endcase
    @(posedge clk);
    {ev_man, ev_chn, ev_hw, ev_nul, ev_srv} <= '0;
    {qev, qnul, qlevel, tcc_out} <= '0;
  endtask
  // A second event of the same trigger is what makes a miss.
  task make_err(input int k, input int ch);
    fire(k, ch);
    if (k < 3 || k == 4)
      fire(k, ch);
  endtask
  initial
  begin
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    for (int a = 0; a <= 48; a += 4)
      rdchk(6'(a), a == 32 ? 32'h2108_4210 : 32'h0000_0000);
    $display("reset values done");
    foreach (ROWS[i])
    begin
      p = pulses;
      make_err(ROWS[i].k, ROWS[i].ch);
      rdchk(ROWS[i].sa, ROWS[i].v);
      repeat (3) @(posedge clk);
      chk(32'(pulses - p), 32'h0000_0001);
      bus(1'b1, ROWS[i].ca, ROWS[i].v);
      rdchk(ROWS[i].sa, 32'h0000_0000);
      $display("row %0d done", i);
    end
    p = pulses;
    fire(0, 5);
    fire(1, 5);
    fire(2, 5);
    rdchk(`OFS_MISS_STAT_LO, 32'h0000_0000);
    fire(2, 5);
    fire(8, 5);
    rdchk(`OFS_MISS_STAT_LO, 32'h0000_0020);
    bus(1'b1, `OFS_MISS_CLR_LO, 32'h0000_0000);
    rdchk(`OFS_MISS_STAT_LO, 32'h0000_0020);
    make_err(3, 6);
    rdchk(`OFS_MISS_STAT_LO, 32'h0000_0060);
    repeat (3) @(posedge clk);
    chk(32'(pulses - p), 32'h0000_0001);
    bus(1'b1, `OFS_MISS_CLR_LO, 32'h0000_0060);
    rdchk(`OFS_MISS_STAT_LO, 32'h0000_0000);
    $display("trigger and sticky test done");
    @(posedge clk);
    qlevel <= 30'h0000_01E0;
    tcc_out <= 7'h3F;
    rdchk(`OFS_CTRL_ERR, 32'h0000_0000);
    @(posedge clk);
    tcc_out <= 7'h00;
    qlevel <= 30'h0000_0010;
    bus(1'b1, `OFS_CTRL_ERR_CLR, 32'h0000_0001);
    rdchk(`OFS_CTRL_ERR, 32'h0000_0001);
    @(posedge clk);
    qlevel <= 30'h0;
    bus(1'b1, `OFS_CTRL_ERR_CLR, 32'h0000_0001);
    rdchk(`OFS_CTRL_ERR, 32'h0000_0000);
    $display("boundary and collision test done");
    bus(1'b1, `OFS_IRQ_CLR, 32'h0000_0001);
    rdchk(`OFS_IRQ_STAT, 32'h0000_0000);
    bus(1'b1, `OFS_IRQ_EN, 32'h0000_0001);
    make_err(7, 0);
    repeat (3) @(posedge clk);
    rdchk(`OFS_IRQ_STAT, 32'h0000_0001);
    chk(32'(irq), 32'h0000_0001);
    bus(1'b1, `OFS_IRQ_EN, 32'h0000_0000);
    repeat (2) @(posedge clk);
    chk(32'(irq), 32'h0000_0000);
    bus(1'b1, `OFS_IRQ_EN, 32'h0000_0001);
    repeat (2) @(posedge clk);
    chk(32'(irq), 32'h0000_0001);
    bus(1'b1, `OFS_CTRL_ERR_CLR, 32'h0001_0000);
    bus(1'b1, `OFS_IRQ_CLR, 32'h0000_0001);
    repeat (2) @(posedge clk);
    chk(32'(irq), 32'h0000_0000);
    rdchk(`OFS_CTRL_ERR, 32'h0000_0000);
    $display("interrupt test done");
    // A reset in mid-run must wipe a flag that is already posted.
    make_err(3, 1);
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    rdchk(`OFS_MISS_STAT_LO, 32'h0000_0000);
    chk(32'(err_int), 32'h0000_0000);
    $display("mid-run reset test done");
    stop_test;
  end
endmodule
